// ===== hdl/bldc_fault_response_unit.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "fault_map.svh"

// Operation
// - stop-on-fault set: short, lost sync or overheat disables all gates
// - latched short disable clears on zero duty, diagnostic read, motor stop or reset
// - undervoltage disables gates while present, whatever stop-on-fault says
// - stop-on-fault clear: short and overheat reported, motor keeps running
// - disabling all outputs drives every gate output low
// - short with stop-on-fault clear removes only the affected gate
// - fault pin is open drain: released or pulled low only
// - indirect mode lost sync gives repeating three-period pulses
// - indirect overheat, stop-on-fault clear, gives repeating four-period
// - single four-period pulse releases the pin and does not repeat
// - pulse: low rest of current period, then two to four periods
// - repeating pulses rest released for same periods, then repeat
// - direct mode holds the fault pin low while any fault exists
module bldc_fault_response_unit
#(
   parameter int unsigned ZERO_DUTY_CYCLES = `ZERO_DUTY_CYCLES,
   parameter int unsigned GATE_COUNT       = 6
)
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   input  wire logic                  ce,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // control pwm pin
   input  wire logic                  pwm_pin,
   // fault detectors
   input  wire logic [GATE_COUNT-1:0] short_fault,
   input  wire logic                  lost_sync,
   input  wire logic                  over_temp,
   input  wire logic                  temp_warning,
   input  wire logic                  vbb_undervoltage,
   // motor controller events
   input  wire logic                  motor_stop,
   input  wire logic                  auto_restart,
   input  wire logic                  diag_read_done,
   // gate drive
   input  wire logic [GATE_COUNT-1:0] gate_drive_in,
   output logic      [GATE_COUNT-1:0] gate_drive_out,
   // open drain fault pin
   output logic                       fault_indicator_pin_n_out,
   output logic                       fault_indicator_pin_n_oe,
   // interrupt
   output logic                       irq
);

   localparam logic [23:0] ZERO_LIMIT = 24'(ZERO_DUTY_CYCLES);

   logic [3:0]            ctrl;
   logic [GATE_COUNT-1:0] short_latched;
   logic                  sync_latched;
   logic                  pwm_s1;
   logic                  pwm_s2;
   logic                  pwm_s3;
   logic                  pwm_level;
   logic                  pwm_prev;
   logic [23:0]           low_count;
   logic [`EV_WIDTH-1:0]  ev_prev;
   logic [`EV_WIDTH-1:0]  int_status;
   logic [`EV_WIDTH-1:0]  int_enable;
   logic                  seq_low;

   // control bits
   wire stop_on_fault_enable      = ctrl[`CTRL_STOP];
   wire indirect_mode             = ctrl[`CTRL_INDIRECT];
   wire auto_restart_control      = ctrl[`CTRL_RESTART];
   wire pwm_input_polarity_invert = ctrl[`CTRL_INVERT];

   // pwm period marks and zero duty detect
   wire pwm_active   = pwm_level ^ pwm_input_polarity_invert;
   wire period_start = pwm_active && !pwm_prev;
   wire zero_duty    = (low_count >= ZERO_LIMIT);

   // fault state
   wire short_any     = |short_fault;
   wire short_held    = |short_latched;
   wire short_clear   = zero_duty || diag_read_done || motor_stop;
   wire sync_state    = lost_sync || sync_latched;
   wire fault_stop    = stop_on_fault_enable &&
                        (short_any || short_held || over_temp);
   wire disable_all   = vbb_undervoltage || sync_state || fault_stop;
   wire any_fault     = vbb_undervoltage || sync_state || short_any ||
                        short_held || over_temp || temp_warning;

   wire [GATE_COUNT-1:0] next_short_latched =
      (short_fault & {GATE_COUNT{stop_on_fault_enable}}) |
      (short_latched & {GATE_COUNT{!short_clear}});
   wire next_sync_latched = (lost_sync && !auto_restart_control) ||
                            (sync_latched && !(motor_stop || auto_restart));
   wire [GATE_COUNT-1:0] gate_mask =
      stop_on_fault_enable ? {GATE_COUNT{1'b1}} : ~short_fault;
   wire [GATE_COUNT-1:0] next_gate_drive_out =
      disable_all ? {GATE_COUNT{1'b0}} : (gate_drive_in & gate_mask);

   // fault pin coding
   wire steady_low = indirect_mode ?
      (vbb_undervoltage || (stop_on_fault_enable && over_temp)) :
      any_fault;
   wire short_sig  = stop_on_fault_enable ? (short_any || short_held) :
                     short_any;
   wire temp_sig   = stop_on_fault_enable ? temp_warning : over_temp;
   wire req_valid  = indirect_mode && (short_sig || sync_state || temp_sig);
   wire [2:0] req_len = short_sig  ? `LEN_SHORT :
                        sync_state ? `LEN_SYNC  :
                        `LEN_TEMP;
   wire req_repeat = short_sig  ? stop_on_fault_enable :
                     sync_state ? 1'b1 :
                     !stop_on_fault_enable;
   wire next_pin_oe = steady_low || seq_low;

   // interrupt events on rising edges of each condition
   wire [`EV_WIDTH-1:0] events = {vbb_undervoltage, temp_warning, over_temp,
                                  lost_sync, short_any};
   wire [`EV_WIDTH-1:0] ev_rise = events & ~ev_prev;

   // register decode
   wire wr_ctrl   = reg_wr && (reg_addr == `ADDR_CTRL);
   wire wr_enable = reg_wr && (reg_addr == `ADDR_INT_ENABLE);
   wire wr_clear  = reg_wr && (reg_addr == `ADDR_INT_CLEAR);
   wire [`EV_WIDTH-1:0] clear_bits =
      wr_clear ? reg_wdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
   // a new event wins over a clear in the same cycle
   wire [`EV_WIDTH-1:0] next_int_status = (int_status & ~clear_bits) | ev_rise;
   wire [31:0] state_word = 32'({fault_indicator_pin_n_oe, disable_all,
                                 sync_latched, short_latched});
   wire [31:0] read_mux =
      (reg_addr == `ADDR_CTRL)       ? 32'(ctrl) :
      (reg_addr == `ADDR_STATE)      ? state_word :
      (reg_addr == `ADDR_INT_STATUS) ? 32'(int_status) :
      (reg_addr == `ADDR_INT_ENABLE) ? 32'(int_enable) :
      32'h0000_0000;

   // pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         pwm_s1    <= 1'b0;
         pwm_s2    <= 1'b0;
         pwm_s3    <= 1'b0;
         pwm_level <= 1'b0;
         pwm_prev  <= 1'b0;
      end
      else if (ce)
      begin
         pwm_s1   <= pwm_pin;
         pwm_s2   <= pwm_s1;
         pwm_s3   <= pwm_s2;
         pwm_prev <= pwm_active;
         if (pwm_s2 == pwm_s3)
            pwm_level <= pwm_s3;
      end
   end

   // zero duty: no active phase seen for the whole timeout
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         low_count <= 24'h000000;
      else if (ce)
      begin
         if (pwm_active)
            low_count <= 24'h000000;
         else if (!zero_duty)
            low_count <= 24'(low_count + 24'h000001);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         short_latched            <= {GATE_COUNT{1'b0}};
         sync_latched             <= 1'b0;
         gate_drive_out           <= {GATE_COUNT{1'b0}};
         fault_indicator_pin_n_oe <= 1'b0;
      end
      else if (ce)
      begin
         short_latched            <= next_short_latched;
         sync_latched             <= next_sync_latched;
         gate_drive_out           <= next_gate_drive_out;
         fault_indicator_pin_n_oe <= next_pin_oe;
      end
   end

   // the pin never drives high; released means high impedance
   assign fault_indicator_pin_n_out = 1'b0;

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ctrl       <= `CTRL_RESET;
         ev_prev    <= {`EV_WIDTH{1'b0}};
         int_status <= {`EV_WIDTH{1'b0}};
         int_enable <= {`EV_WIDTH{1'b0}};
         irq        <= 1'b0;
         reg_rdata  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         ev_prev    <= events;
         int_status <= next_int_status;
         irq        <= |(next_int_status & int_enable);
         reg_rdata  <= reg_rd ? read_mux : 32'h0000_0000;
         if (wr_ctrl)
            ctrl <= reg_wdata[3:0];
         if (wr_enable)
            int_enable <= reg_wdata[`EV_WIDTH-1:0];
      end
   end

   pulse_sequencer u_seq
   (
      .sys_clk      (sys_clk),
      .nrst         (nrst),
      .ce           (ce),
      .period_start (period_start),
      .req_valid    (req_valid),
      .req_len      (req_len),
      .req_repeat   (req_repeat),
      .pin_low      (seq_low)
   );

   default clocking unit_cb @(posedge sys_clk iff ce);
   endclocking
   default disable iff (!nrst);

   a_uv_gates_off: assert property (
      vbb_undervoltage |=> gate_drive_out == {GATE_COUNT{1'b0}})
      else $error("gates driven during undervoltage");

   a_stop_all_gates: assert property (
      stop_on_fault_enable && (over_temp || lost_sync || short_any)
      |=> gate_drive_out == {GATE_COUNT{1'b0}})
      else $error("gates driven after fault with stop-on-fault");

   a_short_hold_off: assert property (
      stop_on_fault_enable && short_any ##1 !short_clear && ce
      |=> gate_drive_out == {GATE_COUNT{1'b0}})
      else $error("latched short released without clear cause");

   a_no_stop_runs: assert property (
      !stop_on_fault_enable && over_temp && !vbb_undervoltage &&
      !sync_state && !short_any
      |=> gate_drive_out == $past(gate_drive_in))
      else $error("motor stopped by overheat with stop-on-fault clear");

   a_short_one_gate: assert property (
      !stop_on_fault_enable && short_fault[0] && gate_drive_in[1] &&
      !short_fault[1] && !vbb_undervoltage && !sync_state
      |=> !gate_drive_out[0] && gate_drive_out[1])
      else $error("short removed the wrong gates");

   a_direct_pin_low: assert property (
      !indirect_mode && any_fault |=> fault_indicator_pin_n_oe)
      else $error("direct mode fault pin not low");

   a_sync_latch_cond: assert property (
      $rose(sync_latched) |-> !$past(auto_restart_control))
      else $error("sync state latched with restart control set");

   a_sync_three_len: assert property (
      indirect_mode && sync_state && !short_sig |-> req_len == `LEN_SYNC)
      else $error("lost sync pulse length wrong");

   a_otemp_four_rep: assert property (
      indirect_mode && !stop_on_fault_enable && over_temp && !short_sig &&
      !sync_state |-> req_len == `LEN_TEMP && req_repeat)
      else $error("overheat pulse not four-period repeating");

   a_pin_only_low: assert property (
      fault_indicator_pin_n_out == 1'b0)
      else $error("fault pin driven high");

   a_short_clear_go: assert property (
      short_clear && !short_any |=> !short_held)
      else $error("latched short not freed by clear cause");

   a_no_stop_latch: assert property (
      !stop_on_fault_enable && !short_held |=> !short_held)
      else $error("short latched with stop-on-fault clear");

   a_sync_clear_go: assert property (
      (motor_stop || auto_restart) && !lost_sync |=> !sync_latched)
      else $error("latched sync not freed by stop or restart");

   a_sync_gates_off: assert property (
      sync_latched |=> gate_drive_out == {GATE_COUNT{1'b0}})
      else $error("gates driven while sync state latched");

   a_uv_pin_low: assert property (
      vbb_undervoltage |=> fault_indicator_pin_n_oe)
      else $error("fault pin released during undervoltage");

   a_short_two_len: assert property (
      indirect_mode && short_sig |-> req_len == `LEN_SHORT)
      else $error("short pulse length wrong");

endmodule

// ===== hdl/fault_map.svh
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

// register offsets
`define ADDR_CTRL        8'h00
`define ADDR_STATE       8'h04
`define ADDR_INT_STATUS  8'h08
`define ADDR_INT_ENABLE  8'h0C
`define ADDR_INT_CLEAR   8'h10

// control register fields
`define CTRL_STOP        0
`define CTRL_INDIRECT    1
`define CTRL_RESTART     2
`define CTRL_INVERT      3
`define CTRL_RESET       4'h0

// event bits of the interrupt registers
`define EV_SHORT         0
`define EV_SYNC          1
`define EV_OTEMP         2
`define EV_TWARN         3
`define EV_UV            4
`define EV_WIDTH         5

// pulse lengths in pwm periods per fault group
`define LEN_SHORT        3'h2
`define LEN_SYNC         3'h3
`define LEN_TEMP         3'h4

// timing
`define CLK_PERIOD_NS    100
`define ZERO_DUTY_TIME_US 1000
`define ZERO_DUTY_CYCLES ((`ZERO_DUTY_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== hdl/fault_pkg.sv
package fault_pkg;

   typedef enum logic [3:0]
   {
      SEQ_IDLE = 4'h1,
      SEQ_LOW  = 4'h2,
      SEQ_HIGH = 4'h4,
      SEQ_DONE = 4'h8
   } seq_state_type;

endpackage

// ===== hdl/pulse_sequencer.sv
`timescale 1ns/100ps
`include "fault_map.svh"

module pulse_sequencer
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   // pwm period marks
   input  wire logic       period_start,
   // coded pulse request
   input  wire logic       req_valid,
   input  wire logic [2:0] req_len,
   input  wire logic       req_repeat,
   // pin drive
   output logic            pin_low
);

   fault_pkg::seq_state_type state;
   fault_pkg::seq_state_type next_state;
   logic [2:0]               cnt;
   logic [2:0]               len;
   logic                     rep;

   wire       low_end  = period_start && (cnt == len);
   wire [2:0] gap_last = 3'(len - 3'h1);
   wire       gap_end  = period_start && (cnt == gap_last);

   always_comb
   begin
      next_state = state;
      case (state)
         fault_pkg::SEQ_IDLE:
            if (req_valid)
               next_state = fault_pkg::SEQ_LOW;
         fault_pkg::SEQ_LOW:
            // a pulse is always finished, even if the fault has gone
            if (low_end)
               next_state = !rep ? fault_pkg::SEQ_DONE :
                            req_valid ? fault_pkg::SEQ_HIGH :
                            fault_pkg::SEQ_IDLE;
         fault_pkg::SEQ_HIGH:
            if (!req_valid)
               next_state = fault_pkg::SEQ_IDLE;
            else if (gap_end)
               next_state = fault_pkg::SEQ_LOW;
         fault_pkg::SEQ_DONE:
            if (!req_valid)
               next_state = fault_pkg::SEQ_IDLE;
         default:
            next_state = fault_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state <= fault_pkg::SEQ_IDLE;
         cnt   <= 3'h0;
         len   <= 3'h0;
         rep   <= 1'b0;
      end
      else if (ce)
      begin
         state <= next_state;
         // repeat pulses start on a period edge, so that edge counts
         if (next_state != state)
            cnt <= (state == fault_pkg::SEQ_HIGH) ? 3'h1 : 3'h0;
         else if (period_start)
            cnt <= 3'(cnt + 3'h1);
         if (state == fault_pkg::SEQ_IDLE)
         begin
            len <= req_len;
            rep <= req_repeat;
         end
      end
   end

   assign pin_low = (state == fault_pkg::SEQ_LOW);

   default clocking seq_cb @(posedge sys_clk iff ce);
   endclocking
   default disable iff (!nrst);

   sequence s_single_end;
      state == fault_pkg::SEQ_LOW && low_end && !rep;
   endsequence

   sequence s_gap_end;
      state == fault_pkg::SEQ_HIGH && req_valid && gap_end;
   endsequence

   a_pulse_starts_low: assert property (
      state == fault_pkg::SEQ_IDLE && req_valid |=> pin_low)
      else $error("coded pulse did not start low");

   a_low_holds_period: assert property (
      state == fault_pkg::SEQ_LOW && !period_start |=> pin_low)
      else $error("coded pulse ended between period edges");

   a_single_no_repeat: assert property (
      s_single_end |=> !pin_low [*2])
      else $error("single pulse was repeated");

   a_repeat_after_gap: assert property (
      s_gap_end |=> pin_low)
      else $error("repeating pulse did not restart after gap");

endmodule

// ===== verification/pwm_partner.sv
`timescale 1ns/100ps

// far-side controller: runs the control pwm and times the fault pin
// protective action is left to the bench, which drives the fault inputs
module pwm_partner
#(
   parameter int PER = 40,
   parameter int HI  = 30
)
(
   // clock and control
   input  wire logic sys_clk,
   input  wire logic run,
   // open drain fault pin
   input  wire logic fault_oe,
   // pwm drive and pin timing
   output logic      pwm_pin,
   output int        low_len,
   output int        high_len
);
   int   ph;
   int   len;
   logic level;
   logic last;

   // pull-up on the wire, so a released pin reads high
   assign level = fault_oe ? 1'b0 : 1'b1;

   initial
   begin
      ph       = 0;
      len      = 0;
      last     = 1'b1;
      pwm_pin  = 1'b0;
      low_len  = 0;
      high_len = 0;
   end

   // idle low when stopped: long low time reads as zero duty
   always @(posedge sys_clk)
   begin
      ph      <= run ? (ph + 1) % PER : 0;
      pwm_pin <= run && (ph < HI);
      last    <= level;
      if (level != last)
      begin
         if (last)
            high_len <= len;
         else
            low_len <= len;
         len <= 1;
      end
      else
         len <= len + 1;
   end
endmodule

// ===== verification/bldc_fault_response_unit_tb.sv
`timescale 1ns/100ps

module bldc_fault_response_unit_tb;
   localparam int PER = 40;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        pwm_pin;
   logic        run = 1'b0;
   logic [5:0]  short_fault = 6'h00;
   logic        lost_sync = 1'b0;
   logic        over_temp = 1'b0;
   logic        temp_warning = 1'b0;
   logic        vbb_undervoltage = 1'b0;
   logic        motor_stop = 1'b0;
   logic        auto_restart = 1'b0;
   logic        diag_read_done = 1'b0;
   logic [5:0]  gate_drive_in = 6'h00;
   logic [5:0]  gate_drive_out;
   logic        pin_out;
   logic        pin_oe;
   logic        irq;
   int          low_len;
   int          high_len;
   int          n_fail = 0;
   int          n_tests = 0;
   int          stop_set = 0;
   logic        ce = 1'b1;
   int          sl = 0;
   int          syl = 0;
   int          cnt;
   logic [31:0] v;

   always #50 sys_clk = ~sys_clk;

   bldc_fault_response_unit #(.ZERO_DUTY_CYCLES(20), .GATE_COUNT(6)) dut
   (
      .sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_pin(pwm_pin),
      .short_fault(short_fault), .lost_sync(lost_sync),
      .over_temp(over_temp), .temp_warning(temp_warning),
      .vbb_undervoltage(vbb_undervoltage), .motor_stop(motor_stop),
      .auto_restart(auto_restart), .diag_read_done(diag_read_done),
      .gate_drive_in(gate_drive_in), .gate_drive_out(gate_drive_out),
      .fault_indicator_pin_n_out(pin_out),
      .fault_indicator_pin_n_oe(pin_oe), .irq(irq)
   );

   pwm_partner #(.PER(PER), .HI(30)) far
   (
      .sys_clk(sys_clk), .run(run), .fault_oe(pin_oe),
      .pwm_pin(pwm_pin), .low_len(low_len), .high_len(high_len)
   );

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic waitc(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   // behavioural gate model from the fault flags
   function automatic logic [5:0] exp_gate(logic [5:0] g, logic [5:0] sh);
      if (vbb_undervoltage || lost_sync || syl != 0)
         return 6'h00;
      if (stop_set != 0 && (sh != 0 || sl != 0 || over_temp))
         return 6'h00;
      return g & ~sh;
   endfunction

   task automatic gate(string nm, logic [5:0] g, logic [5:0] sh);
      @(posedge sys_clk);
      gate_drive_in <= g;
      short_fault   <= sh;
      if (stop_set != 0 && sh != 0)
         sl = 1;
      waitc(3);
      chk(nm, gate_drive_out, exp_gate(g, sh));
   endtask

   task automatic pulse(int which);
      @(posedge sys_clk);
      case (which)
         0: diag_read_done <= 1'b1;
         1: motor_stop <= 1'b1;
         default: auto_restart <= 1'b1;
      endcase
      @(posedge sys_clk);
      diag_read_done <= 1'b0;
      motor_stop     <= 1'b0;
      auto_restart   <= 1'b0;
      waitc(2);
   endtask

   task automatic ctrl(int c);
      stop_set = c & 1;
      wr(8'h00, c);
   endtask

   // run needs about 4000 cycles; the limit allows 10000
   initial
   begin
      #1000000;
      n_fail++;
      final_report();
   end

   initial
   begin
      void'($urandom(68365));
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      run  <= 1'b1;
      @(negedge sys_clk);
      chk("gate_rst", gate_drive_out, 0);
      chk("oe_rst", pin_oe, 0);
      rd(8'h00, v);
      chk("ctrl_rst", v, 0);
      rd(8'hFC, v);
      chk("unmapped", v, 0);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
         gate("pass", $urandom, 6'h00);
      v = 32'(gate_drive_in);
      @(posedge sys_clk);
      ce            <= 1'b0;
      gate_drive_in <= ~gate_drive_in;
      waitc(3);
      chk("ce_freeze", gate_drive_out, exp_gate(v[5:0], 6'h00));
      @(posedge sys_clk);
      ce <= 1'b1;
      for (int i = 0; i < 6; i++)
         gate("short_one", $urandom, 6'h01 << i);
      chk("direct_low", pin_oe, 1);
      chk("drive_low", pin_out, 0);
      @(posedge sys_clk);
      over_temp <= 1'b1;
      gate("ot_keep0", $urandom, 6'h00);
      @(posedge sys_clk);
      over_temp        <= 1'b0;
      vbb_undervoltage <= 1'b1;
      gate("uv_stop0", $urandom, 6'h00);
      ctrl(5);
      gate("uv_stop1", 6'h3F, 6'h00);
      @(posedge sys_clk);
      vbb_undervoltage <= 1'b0;
      gate("uv_gone", 6'h3F, 6'h00);
      $display("test gate path done");
      @(posedge sys_clk);
      over_temp <= 1'b1;
      gate("ot_stop1", 6'h3F, 6'h00);
      @(posedge sys_clk);
      over_temp <= 1'b0;
      lost_sync <= 1'b1;
      gate("sync_stop1", 6'h3F, 6'h00);
      @(posedge sys_clk);
      lost_sync <= 1'b0;
      gate("sync_restart", 6'h3F, 6'h00);
      for (int k = 0; k < 3; k++)
      begin
         gate("short_stop1", $urandom, 6'h04);
         gate("short_held", 6'h3F, 6'h00);
         if (k == 0)
            pulse(0);
         else if (k == 1)
            pulse(1);
         else
         begin
            @(posedge sys_clk);
            run <= 1'b0;
            waitc(40);
            @(posedge sys_clk);
            run <= 1'b1;
         end
         sl = 0;
         gate("short_freed", 6'h3F, 6'h00);
      end
      $display("test stop on fault done");
      ctrl(0);
      lost_sync <= 1'b1;
      gate("sync_on", 6'h2A, 6'h00);
      @(posedge sys_clk);
      lost_sync <= 1'b0;
      syl = 1;
      gate("sync_latch", 6'h2A, 6'h00);
      rd(8'h04, v);
      chk("sync_state", v[6], 1);
      pulse(2);
      syl = 0;
      gate("sync_clear", 6'h2A, 6'h00);
      $display("test sync latch done");
      // inverted polarity: periods then start on falling pwm edges
      ctrl(10);
      lost_sync <= 1'b1;
      waitc(16 * PER);
      chk("p3_low", low_len, 3 * PER);
      chk("p3_high", high_len, 3 * PER);
      @(posedge sys_clk);
      lost_sync <= 1'b0;
      pulse(2);
      waitc(8 * PER);
      @(posedge sys_clk);
      over_temp <= 1'b1;
      gate("ot_run", 6'h15, 6'h00);
      waitc(20 * PER);
      chk("p4_low", low_len, 4 * PER);
      chk("p4_high", high_len, 4 * PER);
      @(posedge sys_clk);
      over_temp <= 1'b0;
      waitc(10 * PER);
      @(posedge sys_clk);
      short_fault <= 6'h01;
      waitc(8 * PER);
      chk("p2_first", low_len > 2 * PER && low_len <= 3 * PER, 1);
      @(posedge sys_clk);
      short_fault <= 6'h00;
      waitc(4 * PER);
      ctrl(3);
      temp_warning <= 1'b1;
      waitc(12 * PER);
      cnt = 0;
      repeat (10 * PER)
      begin
         @(negedge sys_clk);
         cnt += pin_oe;
      end
      chk("p4_single", cnt, 0);
      @(posedge sys_clk);
      temp_warning <= 1'b0;
      $display("test fault pin done");
      wr(8'h10, 32'h1F);
      wr(8'h0C, 32'h10);
      vbb_undervoltage <= 1'b1;
      waitc(3);
      @(posedge sys_clk);
      vbb_undervoltage <= 1'b0;
      waitc(3);
      chk("irq_set", irq, 1);
      rd(8'h08, v);
      chk("status", v[4], 1);
      wr(8'h0C, 32'h00);
      waitc(2);
      chk("irq_mask", irq, 0);
      wr(8'h0C, 32'h10);
      wr(8'h10, 32'h10);
      waitc(2);
      chk("irq_clear", irq, 0);
      rd(8'h08, v);
      chk("status_clr", v[4], 0);
      $display("test interrupt done");
      final_report();
   end
endmodule
